// ==== adc_ctrl.sv ====
// host controller driving an asynchronous 256k x 8 dynamic memory
//
// Overview of operation
// R1 - 200 us pause, then eight row cycles
// R2 - idle over 4 ms repeats wake cycles
// R3 - row then column, nine bits each
// R4 - read access counted from row strobe
// R5 - column strobe once row hold passed
// R6 - honour row, column active and precharge minima
// R7 - read data valid only while column low
// R8 - write strobe high across read column
// R9 - early write: write and data before column
// R10 - strobes held for write lead times
// R11 - page mode cycles column on one row
// R12 - page mixes reads and writes freely
// R13 - refresh one row each 15.6 us
// R14 - normal access refreshes its row
// R15 - row-only refresh with column held high
// R16 - column before row gives counter refresh
// R17 - held column keeps read data during refresh
// R18 - hidden refresh keeps column low over precharge
// R19 - counter test: counter row, external column
// R20 - counter test only after eight refreshes
// R21 - counter test sequence run by software
// R22 - early write keeps device outputs off
// R23 - own refresh timer, refresh beats requests
`default_nettype none
module adc_ctrl #(
    parameter int POWER_UP_CYCLES = adc_pkg::POWER_UP_CYC,
    parameter int WAKE_IDLE_CYCLES = adc_pkg::WAKE_IDLE_CYC,
    parameter int PAGE_RAS_MAX_CYCLES = adc_pkg::PAGE_RAS_MAX_CYC
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // user request
    input wire logic req,
    input wire logic req_we,
    input wire logic req_test,
    input wire logic [adc_pkg::ADDR_W-1:0] req_addr,
    input wire logic [adc_pkg::DATA_W-1:0] req_wdata,
    output logic req_ready,
    // user answer
    output logic rsp_valid,
    output logic rsp_err,
    output logic [adc_pkg::DATA_W-1:0] rsp_rdata,
    output logic init_done,
    // memory pins
    output logic ras_n,
    output logic cas_n,
    output logic we_n,
    output logic [adc_pkg::ROW_W-1:0] mem_addr,
    output logic [adc_pkg::DATA_W-1:0] dq_out,
    output logic dq_oe_n,
    input wire logic [adc_pkg::DATA_W-1:0] dq_in
);
    // ----------------------------------------
    // state and registers
    // ----------------------------------------
    typedef enum {
        S_PWR, S_IDLE, S_CBR_CAS, S_CBR_RAS, S_RO_RAS, S_ROW, S_COL, S_PAGE,
        S_CP, S_CLOSE, S_PRE, S_HID, S_T_CAS, S_T_RAS, S_T_CP
    } adc_state_t;

    localparam int CW = 20;

    adc_state_t state, next_state;
    logic [CW-1:0] cnt, next_cnt;
    logic [CW-1:0] idle_cnt, next_idle_cnt;
    logic [13:0] ras_cnt, next_ras_cnt;
    logic [10:0] ref_cnt, next_ref_cnt;
    logic ref_due, next_ref_due;
    logic [3:0] wake_cnt, next_wake_cnt;
    logic [3:0] cbr_cnt, next_cbr_cnt;
    logic [adc_pkg::ROW_W-1:0] row_ptr, next_row_ptr;
    logic [adc_pkg::ROW_W-1:0] open_row, next_open_row;
    logic page_ok, next_page_ok;
    logic pend, next_pend;
    logic p_we, next_p_we;
    logic p_test, next_p_test;
    logic [adc_pkg::ADDR_W-1:0] p_addr, next_p_addr;
    logic [adc_pkg::DATA_W-1:0] p_data, next_p_data;
    logic next_req_ready, next_rsp_valid, next_rsp_err, next_init_done;
    logic [adc_pkg::DATA_W-1:0] next_rsp_rdata;
    logic next_ras_n, next_cas_n, next_we_n, next_dq_oe_n;
    logic [adc_pkg::ROW_W-1:0] next_mem_addr;
    logic [adc_pkg::DATA_W-1:0] next_dq_out;
    logic [adc_pkg::DATA_W-1:0] dq_s1, dq_s2;
    logic take;

    function automatic logic reached(input logic [CW-1:0] c, input int n);
        return c >= CW'(n - 1);
    endfunction

    // ----------------------------------------
    // next values
    // ----------------------------------------
    always_comb begin
        next_state = state;
        next_cnt = cnt + CW'(1);
        next_ref_cnt = ref_cnt + 11'h001;
        next_ref_due = ref_due;
        next_wake_cnt = wake_cnt;
        next_cbr_cnt = cbr_cnt;
        next_row_ptr = row_ptr;
        next_open_row = open_row;
        next_page_ok = page_ok;
        next_pend = pend;
        next_p_we = p_we;
        next_p_test = p_test;
        next_p_addr = p_addr;
        next_p_data = p_data;
        next_rsp_valid = 1'b0;
        next_rsp_err = rsp_err;
        next_rsp_rdata = rsp_rdata;
        next_ras_n = ras_n;
        next_cas_n = cas_n;
        next_we_n = we_n;
        next_mem_addr = mem_addr;
        next_dq_out = dq_out;
        next_dq_oe_n = dq_oe_n;
        take = req && req_ready;
        if (take) begin
            if (req_test && cbr_cnt < 4'(adc_pkg::TEST_INIT_CYCLES)) begin
                next_rsp_valid = 1'b1; // see R20
                next_rsp_err = 1'b1;
            end else begin
                next_pend = 1'b1;
                next_p_we = req_we;
                next_p_test = req_test;
                next_p_addr = req_addr;
                next_p_data = req_wdata;
            end
        end
        case (state)
            S_PWR: begin
                if (reached(cnt, POWER_UP_CYCLES)) begin // see R1
                    next_state = S_IDLE;
                    next_cnt = '0;
                end
            end
            S_IDLE: begin
                next_mem_addr = ref_due ? row_ptr : next_p_addr[adc_pkg::ADDR_W-1:adc_pkg::COL_W]; // see R3
                if (cnt != '0) begin
                    next_cnt = '0;
                    if (wake_cnt < 4'(adc_pkg::WAKE_RAS_CYCLES)) begin
                        next_cas_n = 1'b0; // see R1 see R2
                        next_state = S_CBR_CAS;
                    end else if (ref_due) begin
                        next_ras_n = mem_addr != row_ptr; // see R15 see R23
                        next_state = (mem_addr == row_ptr) ? S_RO_RAS : S_IDLE;
                    end else if (pend) begin
                        next_pend = 1'b0;
                        if (p_test) begin
                            next_cas_n = 1'b0;
                            next_state = S_T_CAS;
                        end else begin
                            next_ras_n = 1'b0;
                            next_open_row = p_addr[adc_pkg::ADDR_W-1:adc_pkg::COL_W];
                            next_state = S_ROW;
                        end
                    end
                end
            end
            S_CBR_CAS: begin
                if (reached(cnt, adc_pkg::CSR_CYC)) begin
                    next_ras_n = 1'b0; // see R16
                    next_cnt = '0;
                    next_state = S_CBR_RAS;
                end
            end
            S_CBR_RAS: begin
                if (reached(cnt, adc_pkg::CHR_CYC)) begin
                    next_cas_n = 1'b1;
                end
                if (reached(cnt, adc_pkg::RAS_CYC)) begin
                    next_ras_n = 1'b1; // see R6
                    next_cas_n = 1'b1;
                    next_ref_due = 1'b0;
                    if (cbr_cnt < 4'(adc_pkg::TEST_INIT_CYCLES)) begin
                        next_cbr_cnt = cbr_cnt + 4'h1; // see R20
                    end
                    next_cnt = '0;
                    next_state = S_PRE;
                end
            end
            S_RO_RAS: begin
                if (reached(cnt, adc_pkg::RAS_CYC)) begin
                    next_ras_n = 1'b1;
                    next_ref_due = 1'b0;
                    next_row_ptr = row_ptr + 9'h001; // see R13
                    next_cnt = '0;
                    next_state = S_PRE;
                end
            end
            S_PRE: begin
                if (reached(cnt, adc_pkg::RP_CYC)) begin // see R6
                    next_cnt = '0;
                    next_state = S_IDLE;
                end
            end
            S_ROW: begin
                if (cnt == CW'(adc_pkg::RAH_CYC - 1)) begin
                    next_mem_addr = p_addr[adc_pkg::COL_W-1:0]; // see R5
                    next_we_n = !p_we; // see R8 see R9
                    next_dq_out = p_data;
                    next_dq_oe_n = !p_we;
                end
                if (reached(cnt, adc_pkg::RCD_CYC)) begin
                    next_cas_n = 1'b0; // see R4 see R5
                    next_page_ok = 1'b1;
                    next_cnt = '0;
                    next_state = S_COL;
                end
            end
            S_COL: begin
                if (reached(cnt, p_we ? adc_pkg::COL_WR_CYC : adc_pkg::COL_RD_CYC)) begin // see R10
                    next_cnt = '0;
                    next_we_n = 1'b1;
                    next_dq_oe_n = 1'b1;
                    if (!p_we) begin
                        next_rsp_rdata = dq_s2; // see R7
                    end
                    next_rsp_valid = 1'b1;
                    next_rsp_err = 1'b0;
                    if (!p_we && ref_due && !p_test) begin
                        next_ras_n = 1'b1; // see R18
                        next_state = S_HID;
                    end else begin
                        next_cas_n = 1'b1;
                        next_page_ok = !p_test; // see R19
                        next_state = S_PAGE;
                    end
                end
            end
            S_HID: begin
                if (reached(cnt, adc_pkg::RP_CYC)) begin
                    next_ras_n = 1'b0; // see R17 see R18
                    next_cnt = '0;
                    next_state = S_CBR_RAS;
                end
            end
            S_PAGE: begin
                if (take && !next_pend) begin
                    next_state = S_PAGE;
                end else if (take && !req_test && page_ok &&
                             req_addr[adc_pkg::ADDR_W-1:adc_pkg::COL_W] == open_row) begin
                    next_pend = 1'b0; // see R11 see R12
                    next_mem_addr = req_addr[adc_pkg::COL_W-1:0];
                    next_we_n = !req_we;
                    next_dq_out = req_wdata;
                    next_dq_oe_n = !req_we;
                    next_cnt = '0;
                    next_state = S_CP;
                end else if (take || ref_due || !page_ok ||
                             ras_cnt >= 14'(PAGE_RAS_MAX_CYCLES - 1)) begin
                    next_state = S_CLOSE; // see R23
                end
            end
            S_CP: begin
                if (reached(cnt, adc_pkg::CP_CYC)) begin
                    next_cas_n = 1'b0;
                    next_cnt = '0;
                    next_state = S_COL;
                end
            end
            S_CLOSE: begin
                if (ras_cnt >= 14'(adc_pkg::RAS_CYC)) begin // see R6 see R14
                    next_ras_n = 1'b1;
                    next_cnt = '0;
                    next_state = S_PRE;
                end
            end
            S_T_CAS: begin
                if (reached(cnt, adc_pkg::CSR_CYC)) begin
                    next_ras_n = 1'b0; // see R19 see R21
                    next_cnt = '0;
                    next_state = S_T_RAS;
                end
            end
            S_T_RAS: begin
                if (reached(cnt, adc_pkg::CHR_CYC)) begin
                    next_cas_n = 1'b1;
                    next_mem_addr = p_addr[adc_pkg::COL_W-1:0]; // see R19
                    next_we_n = !p_we;
                    next_dq_out = p_data;
                    next_dq_oe_n = !p_we;
                    next_cnt = '0;
                    next_state = S_T_CP;
                end
            end
            S_T_CP: begin
                if (reached(cnt, adc_pkg::CPT_CYC)) begin
                    next_cas_n = 1'b0;
                    next_cnt = '0;
                    next_state = S_COL;
                end
            end
            default: begin
                next_state = S_IDLE;
            end
        endcase
        // refresh timer: a new deadline beats the clear
        if (ref_cnt >= 11'(adc_pkg::REFRESH_CYC - 1)) begin
            next_ref_cnt = '0;
            next_ref_due = 1'b1; // see R13 see R23
        end
        // each completed row cycle counts toward wake
        if (next_ras_n && !ras_n && wake_cnt < 4'(adc_pkg::WAKE_RAS_CYCLES)) begin
            next_wake_cnt = wake_cnt + 4'h1;
        end
        next_idle_cnt = ras_n ? ((idle_cnt == '1) ? idle_cnt : idle_cnt + CW'(1)) : '0;
        if (idle_cnt >= CW'(WAKE_IDLE_CYCLES)) begin
            next_wake_cnt = '0; // see R2
        end
        next_ras_cnt = next_ras_n ? '0 : ras_cnt + 14'h0001;
        next_init_done = next_wake_cnt >= 4'(adc_pkg::WAKE_RAS_CYCLES);
        next_req_ready = !next_pend && !next_ref_due && next_init_done &&
                         (next_state == S_IDLE || next_state == S_PAGE); // see R23
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            state <= S_PWR;
            cnt <= '0;
            idle_cnt <= '0;
            ras_cnt <= '0;
            ref_cnt <= '0;
            ref_due <= 1'b0;
            wake_cnt <= '0;
            cbr_cnt <= '0;
            row_ptr <= '0;
            open_row <= '0;
            page_ok <= 1'b0;
            pend <= 1'b0;
            p_we <= 1'b0;
            p_test <= 1'b0;
            p_addr <= '0;
            p_data <= '0;
            req_ready <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_err <= 1'b0;
            rsp_rdata <= '0;
            init_done <= 1'b0;
            ras_n <= 1'b1;
            cas_n <= 1'b1;
            we_n <= 1'b1;
            mem_addr <= '0;
            dq_out <= '0;
            dq_oe_n <= 1'b1;
            dq_s1 <= '0;
            dq_s2 <= '0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            idle_cnt <= next_idle_cnt;
            ras_cnt <= next_ras_cnt;
            ref_cnt <= next_ref_cnt;
            ref_due <= next_ref_due;
            wake_cnt <= next_wake_cnt;
            cbr_cnt <= next_cbr_cnt;
            row_ptr <= next_row_ptr;
            open_row <= next_open_row;
            page_ok <= next_page_ok;
            pend <= next_pend;
            p_we <= next_p_we;
            p_test <= next_p_test;
            p_addr <= next_p_addr;
            p_data <= next_p_data;
            req_ready <= next_req_ready;
            rsp_valid <= next_rsp_valid;
            rsp_err <= next_rsp_err;
            rsp_rdata <= next_rsp_rdata;
            init_done <= next_init_done;
            ras_n <= next_ras_n;
            cas_n <= next_cas_n;
            we_n <= next_we_n;
            mem_addr <= next_mem_addr;
            dq_out <= next_dq_out;
            dq_oe_n <= next_dq_oe_n; // see R22
            dq_s1 <= dq_in;
            dq_s2 <= dq_s1;
        end
    end
endmodule
`default_nettype wire

// ==== adc_pkg.sv ====
// constants shared by the dynamic memory controller
`default_nettype none
package adc_pkg;
    // ----------------------------------------
    // clock and conversion helpers
    // ----------------------------------------
    localparam int CLK_NS = 10;

    // least time: round up, never below one cycle
    function automatic int cyc_up(input int ns);
        int c;
        c = (ns + CLK_NS - 1) / CLK_NS;
        return (c < 1) ? 1 : c;
    endfunction

    // longest time: round down, never below one cycle
    function automatic int cyc_dn(input int ns);
        int c;
        c = ns / CLK_NS;
        return (c < 1) ? 1 : c;
    endfunction

    function automatic int max2(input int a, input int b);
        return (a > b) ? a : b;
    endfunction

    // ----------------------------------------
    // geometry
    // ----------------------------------------
    localparam int ROW_W = 9;
    localparam int COL_W = 9;
    localparam int ADDR_W = ROW_W + COL_W;
    localparam int DATA_W = 8;

    // ----------------------------------------
    // sequence figures
    // ----------------------------------------
    localparam int POWER_UP_US = 200;
    localparam int WAKE_IDLE_MS = 4;
    localparam int WAKE_RAS_CYCLES = 8;
    localparam int TEST_INIT_CYCLES = 8;
    localparam real REFRESH_EVERY_US = 15.6;
    localparam int PAGE_RAS_MAX_NS = 100000;
    localparam int SYNC_STAGES = 2;

    localparam int POWER_UP_CYC = cyc_up(POWER_UP_US * 1000);
    localparam int WAKE_IDLE_CYC = cyc_dn(WAKE_IDLE_MS * 1000000);
    localparam int REFRESH_CYC = $rtoi(REFRESH_EVERY_US * 1000.0 / CLK_NS);
    localparam int PAGE_RAS_MAX_CYC = cyc_dn(PAGE_RAS_MAX_NS);

    // ----------------------------------------
    // strobe timing, ns
    // ----------------------------------------
    localparam int ROW_TO_COLUMN_DELAY_NS = 20;
    localparam int ROW_ACTIVE_MIN_NS = 70;
    localparam int COLUMN_ACTIVE_MIN_NS = 20;
    localparam int ROW_PRECHARGE_MIN_NS = 50;
    localparam int ROW_ADDR_HOLD_NS = 10;
    localparam int REFRESH_COLUMN_SETUP_NS = 10;
    localparam int REFRESH_COLUMN_HOLD_NS = 30;
    localparam int TEST_COLUMN_PRECHARGE_NS = 40;
    localparam int PAGE_COLUMN_PRECHARGE_NS = 10;
    localparam int COLUMN_ACCESS_TIME_NS = 20;
    localparam int ROW_ACCESS_TIME_NS = 70;
    localparam int COLUMN_WRITE_LEAD_NS = 20;
    localparam int ROW_WRITE_LEAD_NS = 20;

    localparam int RCD_CYC = cyc_up(ROW_TO_COLUMN_DELAY_NS);
    localparam int RAS_CYC = cyc_up(ROW_ACTIVE_MIN_NS);
    localparam int RP_CYC = cyc_up(ROW_PRECHARGE_MIN_NS);
    localparam int RAH_CYC = cyc_up(ROW_ADDR_HOLD_NS);
    localparam int CSR_CYC = cyc_up(REFRESH_COLUMN_SETUP_NS);
    localparam int CHR_CYC = cyc_up(REFRESH_COLUMN_HOLD_NS);
    localparam int CPT_CYC = cyc_up(TEST_COLUMN_PRECHARGE_NS);
    localparam int CP_CYC = cyc_up(PAGE_COLUMN_PRECHARGE_NS);
    localparam int COL_WR_CYC = max2(cyc_up(COLUMN_ACTIVE_MIN_NS),
        max2(cyc_up(COLUMN_WRITE_LEAD_NS), cyc_up(ROW_WRITE_LEAD_NS)));
    localparam int COL_RD_CYC = max2(cyc_up(COLUMN_ACTIVE_MIN_NS),
        max2(cyc_up(COLUMN_ACCESS_TIME_NS), cyc_up(ROW_ACCESS_TIME_NS) - RCD_CYC)) + SYNC_STAGES;
endpackage
`default_nettype wire

// ==== adc_dram_model.sv ====
// behavioural dynamic memory standing on the far side of the controller
`default_nettype none
module adc_dram_model (
    // strobes
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    // address and data
    input wire logic [adc_pkg::ROW_W-1:0] mem_addr,
    input wire logic [adc_pkg::DATA_W-1:0] dq_out,
    input wire logic dq_oe_n,
    output logic [adc_pkg::DATA_W-1:0] dq_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // cells never decay in the model
    logic [7:0] cells [bit [17:0]];
    logic [8:0] row;
    logic [8:0] ctr = 9'h000;
    logic rd_on = 1'b0;
    logic [7:0] rd_data = 8'h00;
    // ----------------------------------------
    // row latch and refresh counter
    // ----------------------------------------
    always @(negedge ras_n) begin
        if (!cas_n) begin
            row = ctr;
            ctr = ctr + 9'd1;
        end else begin
            row = mem_addr;
        end
    end
    // ----------------------------------------
    // column access, gated by row strobe
    // ----------------------------------------
    always @(negedge cas_n) begin
        if (!ras_n) begin
            if (!we_n) begin
                rd_on = 1'b0;
                cells[{row, mem_addr}] = dq_oe_n ? ~dq_out : dq_out;
            end else begin
                rd_on = 1'b1;
                rd_data = cells.exists({row, mem_addr}) ? cells[{row, mem_addr}] : 8'h00;
            end
        end
    end
    // output kept while column low, off when it rises
    always @(posedge cas_n) rd_on = 1'b0;
    assign dq_in = rd_on ? rd_data : ~rd_data;
endmodule
`default_nettype wire

// ==== adc_ctrl_props.sv ====
// strobe ordering checks for the dynamic memory controller
`default_nettype none
module adc_ctrl_props #(
    parameter int POWER_UP_CYCLES = 50,
    parameter int WAKE_IDLE_CYCLES = 200,
    parameter int PAGE_RAS_MAX_CYCLES = 40
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // user side
    input wire logic req_ready,
    input wire logic rsp_valid,
    input wire logic init_done,
    // memory strobes
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic dq_oe_n
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int REFRESH_LIMIT = 1700;
    logic ras_q;
    int gap;
    int since_rst;
    int falls;
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    // ----------------------------------------
    // helper counters
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            ras_q <= 1'b1;
            gap <= 0;
            since_rst <= 0;
            falls <= 0;
        end else begin
            ras_q <= ras_n;
            since_rst <= (since_rst < 1000000) ? since_rst + 1 : since_rst;
            gap <= (ras_q && !ras_n) ? 0 : gap + 1;
            falls <= (ras_q && !ras_n && falls < 15) ? falls + 1 : falls;
        end
    end
    // ----------------------------------------
    // assertions
    // ----------------------------------------
    a_reset_idle: assert property ($fell(rst) |-> ras_n && cas_n && dq_oe_n && !req_ready && !rsp_valid)
        else $error("strobes not idle after reset");
    a_power_pause: assert property ($fell(ras_n) |-> since_rst >= POWER_UP_CYCLES)
        else $error("row strobe before power-up pause");
    a_ready_after_init: assert property (req_ready |-> init_done && falls >= 8)
        else $error("ready before eight row cycles");
    a_rcd_gap: assert property ($fell(cas_n) && !ras_n |-> $past(ras_n, 2) == 1'b0)
        else $error("column strobe too soon after row");
    a_ras_active: assert property ($fell(ras_n) |-> !ras_n [*7])
        else $error("row strobe active too short");
    a_precharge_min: assert property ($rose(ras_n) |-> ras_n [*5])
        else $error("row precharge too short");
    a_cas_active: assert property ($fell(cas_n) && !ras_n |-> !cas_n [*2])
        else $error("column strobe active too short");
    a_write_lead: assert property ($fell(cas_n) && !ras_n && !we_n |->
        (!cas_n && !ras_n && !we_n && !dq_oe_n) [*2])
        else $error("early write strobes released early");
    a_read_no_drive: assert property ($fell(cas_n) && !ras_n && we_n |-> (we_n && dq_oe_n) [*3])
        else $error("write strobe or data moved in read");
    a_no_contention: assert property (!cas_n && we_n |-> dq_oe_n)
        else $error("controller drives data during read");
    a_cbr_setup: assert property ($fell(ras_n) && !cas_n |-> $past(cas_n) == 1'b0)
        else $error("column not set up before refresh");
    a_refresh_gap: assert property (init_done |-> gap < REFRESH_LIMIT)
        else $error("refresh interval exceeded");
    c_counter_refresh: cover property ($fell(ras_n) && !cas_n);
    c_hidden_refresh: cover property ($rose(ras_n) && !cas_n);
    c_early_write: cover property ($fell(cas_n) && !we_n);
endmodule
bind adc_ctrl adc_ctrl_props #(
    .POWER_UP_CYCLES(POWER_UP_CYCLES),
    .WAKE_IDLE_CYCLES(WAKE_IDLE_CYCLES),
    .PAGE_RAS_MAX_CYCLES(PAGE_RAS_MAX_CYCLES)
) u_props (
    .clock(clock),
    .rst(rst),
    .req_ready(req_ready),
    .rsp_valid(rsp_valid),
    .init_done(init_done),
    .ras_n(ras_n),
    .cas_n(cas_n),
    .we_n(we_n),
    .dq_oe_n(dq_oe_n)
);
`default_nettype wire

// ==== tb_adc_ctrl.sv ====
// self-checking bench for the dynamic memory controller
`default_nettype none
module tb_adc_ctrl;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int PU = 50;
    localparam int WAKE = 200;
    localparam logic [8:0] COL = 9'd77;
    logic clock, rst, req, req_we, req_test, req_ready, rsp_valid, rsp_err, init_done;
    logic ras_n, cas_n, we_n, dq_oe_n;
    logic [adc_pkg::ADDR_W-1:0] req_addr;
    logic [adc_pkg::DATA_W-1:0] req_wdata, rsp_rdata, dq_out, dq_in;
    logic [adc_pkg::ROW_W-1:0] mem_addr;
    int mismatches, samples_checked;
    int ras_falls = 0;
    adc_ctrl #(.POWER_UP_CYCLES(PU), .WAKE_IDLE_CYCLES(WAKE), .PAGE_RAS_MAX_CYCLES(40)) uut (
        .clock(clock), .rst(rst), .req(req), .req_we(req_we), .req_test(req_test),
        .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready),
        .rsp_valid(rsp_valid), .rsp_err(rsp_err), .rsp_rdata(rsp_rdata), .init_done(init_done),
        .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .mem_addr(mem_addr),
        .dq_out(dq_out), .dq_oe_n(dq_oe_n), .dq_in(dq_in)
    );
    adc_dram_model u_mem (
        .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .mem_addr(mem_addr),
        .dq_out(dq_out), .dq_oe_n(dq_oe_n), .dq_in(dq_in)
    );
    always @(negedge ras_n) ras_falls++;
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic timeout(input string what);
        mismatches++;
        $display("Error %s wait ran out", what);
        summarize();
    endtask
    task automatic wait_ready();
        int n = 0;
        while (req_ready !== 1'b1) begin
            @(posedge clock);
            #1;
            n++;
            if (n > 4000) timeout("req_ready");
        end
    endtask
    task automatic xfer(input logic we, input logic tst, input logic [17:0] a, input logic [7:0] d,
                        output logic [7:0] q);
        int n = 0;
        wait_ready();
        req = 1'b1;
        req_we = we;
        req_test = tst;
        req_addr = a;
        req_wdata = d;
        @(posedge clock);
        #1;
        req = 1'b0;
        while (rsp_valid !== 1'b1) begin
            @(posedge clock);
            #1;
            n++;
            if (n > 300) timeout("rsp_valid");
        end
        q = rsp_rdata;
        check("rsp_err", 8'(rsp_err), 8'h00);
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_init();
        wait_ready();
        check("init_done", 8'(init_done), 8'h01);
        check("wake row cycles", 8'(ras_falls >= 8), 8'h01);
        $display("init test done");
    endtask
    task automatic t_page();
        logic [7:0] q;
        xfer(1'b1, 1'b0, {9'd5, 9'd3}, 8'h3C, q);
        xfer(1'b1, 1'b0, {9'd5, 9'd511}, 8'hC3, q);
        xfer(1'b0, 1'b0, {9'd5, 9'd3}, 8'h00, q);
        check("page read", q, 8'h3C);
        xfer(1'b1, 1'b0, {9'd511, 9'd0}, 8'h81, q);
        xfer(1'b0, 1'b0, {9'd5, 9'd511}, 8'h00, q);
        check("row read", q, 8'hC3);
        xfer(1'b0, 1'b0, {9'd511, 9'd0}, 8'h00, q);
        check("far row read", q, 8'h81);
        $display("page test done");
    endtask
    task automatic t_wake();
        logic [7:0] q;
        int base = ras_falls;
        repeat (WAKE + 100) @(posedge clock);
        #1;
        xfer(1'b0, 1'b0, {9'd5, 9'd3}, 8'h00, q);
        check("wake read", q, 8'h3C);
        check("wake row cycles", 8'(ras_falls - base >= 9), 8'h01);
        $display("wake test done");
    endtask
    task automatic t_counter(input logic [7:0] d);
        logic [7:0] q;
        for (int r = 0; r < 512; r++) begin
            xfer(1'b1, 1'b0, {r[8:0], COL}, d, q);
        end
        for (int r = 0; r < 512; r++) begin
            xfer(1'b0, 1'b1, {9'd0, COL}, 8'h00, q);
            check("counter read", q, d);
        end
        for (int r = 0; r < 512; r++) begin
            xfer(1'b1, 1'b1, {9'd0, COL}, ~d, q);
        end
        for (int r = 0; r < 512; r++) begin
            xfer(1'b0, 1'b0, {r[8:0], COL}, 8'h00, q);
            check("counter row", q, ~d);
        end
        $display("counter test done");
    endtask
    // ----------------------------------------
    // clock, watchdog and main sequence
    // ----------------------------------------
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    initial begin
        repeat (100000) @(posedge clock);
        timeout("run");
    end
    initial begin
        rst = 1'b1;
        req = 1'b0;
        req_we = 1'b0;
        req_test = 1'b0;
        req_addr = 18'h0_0000;
        req_wdata = 8'h00;
        mismatches = 0;
        samples_checked = 0;
        repeat (4) @(posedge clock);
        #1;
        rst = 1'b0;
        t_init();
        t_page();
        t_wake();
        t_counter(8'h00);
        t_counter(8'hFF);
        summarize();
    end
endmodule
`default_nettype wire
